//--- verilog/supply_fault_pkg.sv
// constants, fault table and state codes for the supply fault supervisor
// assumes a 10 MHz system clock and a 0.1 s supervision tick
package supply_fault_pkg;

   // clock and tick timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_PERIOD_MS = 100;
   localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

   // lock times, in ms, and in ticks
   localparam int LOCK_VOLT_MS = 5000;
   localparam int LOCK_STD_MS = 10000;
   localparam int LOCK_LOGIC_MS = 100;
   localparam int LOCK_ENERGY_MS = 100000;
   localparam logic [15:0] LOCK_NONE = 16'h0000;
   localparam logic [15:0] LOCK_VOLT = 16'(LOCK_VOLT_MS / TICK_PERIOD_MS);
   localparam logic [15:0] LOCK_STD = 16'(LOCK_STD_MS / TICK_PERIOD_MS);
   localparam logic [15:0] LOCK_LOGIC = 16'(LOCK_LOGIC_MS / TICK_PERIOD_MS);
   localparam logic [15:0] LOCK_ENERGY = 16'(LOCK_ENERGY_MS / TICK_PERIOD_MS);

   // accumulator discharge: ms per 1 % step, and ticks per step
   localparam int BRAKE_STEP_MS = 500;
   localparam int CABLE_STEP_MS = 24800;
   localparam int BRAKE_STEP_TICKS = BRAKE_STEP_MS / TICK_PERIOD_MS;
   localparam int CABLE_STEP_TICKS = CABLE_STEP_MS / TICK_PERIOD_MS;
   localparam logic [6:0] LEVEL_FULL = 7'h64;
   localparam logic [6:0] LEVEL_HALF = 7'h32;
   localparam logic [6:0] LEVEL_EMPTY = 7'h00;

   // register offsets
   localparam logic [11:0] REG_FAULT_HOLD_TIME = 12'h814;
   localparam logic [11:0] REG_AUTO_RESTART = 12'h835;
   localparam logic [15:0] FAULT_HOLD_TIME_RESET = 16'h0000;
   localparam logic [15:0] AUTO_RESTART_RESET = 16'h0000;
   localparam logic [15:0] AUTO_RESTART_ON = 16'h0001;

   // fault source indices
   localparam int NUM_SRC = 21;
   localparam int F_UNDERVOLT = 0;
   localparam int F_OVERVOLT = 1;
   localparam int F_RIPPLE = 2;
   localparam int F_TEMP_LOGIC = 3;
   localparam int F_TEMP_POWER = 4;
   localparam int F_OVERCURRENT = 5;
   localparam int F_DEV_ENERGY = 6;
   localparam int F_BRAKE_ENERGY = 7;
   localparam int F_BRAKE_OVERVOLT = 8;
   localparam int F_POWER_MISSING = 9;
   localparam int F_BRAKE_SHORT = 10;
   localparam int F_LOGIC_MISSING = 11;
   localparam int F_CHARGE_ENERGY = 12;
   localparam int F_CONFIG = 13;
   localparam int F_DEV_CH1 = 14;
   localparam int F_DEV_CH2 = 15;
   localparam int F_INPUT_RIPPLE = 16;
   localparam int F_INPUT_FALL = 17;
   localparam int F_CABLE_CH1 = 18;
   localparam int F_CABLE_CH2 = 19;
   localparam int F_HW_CONFIG = 20;

   // class masks: bit set where the source belongs to the class
   localparam logic [NUM_SRC-1:0] WARN_MASK = 21'h0cc1d8;
   localparam logic [NUM_SRC-1:0] FAULT_MASK = 21'h1ffeff;
   localparam logic [NUM_SRC-1:0] ENERGY_MASK = 21'h0cd0c0;

   typedef enum logic [2:0] {
      ST_MAINS_WAIT = 3'h0,
      ST_STARTUP = 3'h1,
      ST_BUS_CHECK = 3'h2,
      ST_OPERATIONAL = 3'h3,
      ST_WARNING = 3'h4,
      ST_FAULT = 3'h5,
      ST_POWER_DOWN = 3'h6
   } supply_state_t;

   typedef enum logic [1:0] {
      LAMP_OFF = 2'h0,
      LAMP_GREEN = 2'h1,
      LAMP_ORANGE = 2'h2,
      LAMP_RED = 2'h3
   } lamp_t;

   function automatic logic [4:0] code_of(input int idx);
      case (idx)
         F_UNDERVOLT: code_of = 5'h01;
         F_OVERVOLT: code_of = 5'h02;
         F_RIPPLE: code_of = 5'h03;
         F_TEMP_LOGIC: code_of = 5'h04;
         F_TEMP_POWER: code_of = 5'h05;
         F_OVERCURRENT: code_of = 5'h06;
         F_DEV_ENERGY: code_of = 5'h07;
         F_BRAKE_ENERGY: code_of = 5'h08;
         F_POWER_MISSING: code_of = 5'h09;
         F_BRAKE_SHORT: code_of = 5'h0a;
         F_LOGIC_MISSING: code_of = 5'h0b;
         F_CHARGE_ENERGY: code_of = 5'h0c;
         F_CONFIG: code_of = 5'h0d;
         F_DEV_CH1: code_of = 5'h10;
         F_DEV_CH2: code_of = 5'h11;
         F_INPUT_RIPPLE: code_of = 5'h12;
         F_INPUT_FALL: code_of = 5'h13;
         F_HW_CONFIG: code_of = 5'h14;
         F_CABLE_CH1: code_of = 5'h15;
         F_CABLE_CH2: code_of = 5'h16;
         default: code_of = 5'h00;
      endcase
   endfunction

   function automatic logic [15:0] lock_of(input int idx);
      case (idx)
         F_UNDERVOLT, F_OVERVOLT, F_INPUT_FALL: lock_of = LOCK_VOLT;
         F_LOGIC_MISSING: lock_of = LOCK_LOGIC;
         F_CHARGE_ENERGY, F_CABLE_CH1, F_CABLE_CH2: lock_of = LOCK_ENERGY;
         F_BRAKE_OVERVOLT, F_POWER_MISSING, F_CONFIG: lock_of = LOCK_NONE;
         default: lock_of = LOCK_STD;
      endcase
   endfunction

   // longest lock time among the flagged sources
   function automatic logic [15:0] max_lock(input logic [NUM_SRC-1:0] flags);
      logic [15:0] m;
      m = LOCK_NONE;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (flags[i] && lock_of(i) > m) begin
            m = lock_of(i);
         end
      end
      max_lock = m;
   endfunction

   // code of the lowest-index flagged source, zero when none
   function automatic logic [4:0] first_code(input logic [NUM_SRC-1:0] flags);
      logic [4:0] c;
      c = 5'h00;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (flags[i]) begin
            c = code_of(i);
         end
      end
      first_code = c;
   endfunction

endpackage

//--- verilog/energy_accumulator.sv
// retentive energy accumulator in percent, with a fixed discharge step
// assumes charge pulses of 1 % and a tick strobe from the supervisor
`timescale 1ns/1ps
module energy_accumulator #(
   parameter int STEP_TICKS = 5
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // strobes
   input wire logic tick,
   input wire logic charge,
   // level
   output logic [6:0] level,
   output logic full,
   output logic above_half
);
   import supply_fault_pkg::*;

   logic [15:0] step_cnt;

   // level is not touched by control supply loss, only by system reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         level <= LEVEL_EMPTY;
         step_cnt <= 16'h0000;
      end else begin
         if (charge && level != 7'h7f) begin
            level <= level + 7'h01;
         end else if (tick) begin
            if (step_cnt >= 16'(STEP_TICKS - 1)) begin
               step_cnt <= 16'h0000;
               if (level != LEVEL_EMPTY) begin
                  level <= level - 7'h01;
               end
            end else begin
               step_cnt <= step_cnt + 16'h0001;
            end
         end
      end
   end

   assign full = (level >= LEVEL_FULL);
   assign above_half = (level > LEVEL_HALF) && !full;

endmodule // energy_accumulator

//--- verilog/supply_fault_supervisor.sv
// fault and warning supervisor for a dc supply: latching, lock timing, restart
// assumes synchronous monitor inputs and a synchronous active-high reset
//
// Summary of operation
// - in operational, warning or bus-check, any live fault enters the fault state.
// - entering fault opens the trip contact, removing mains power.
// - status lamp shows red while in the fault state.
// - each source is classed as warning, fault or both.
// - dynamic flags follow the live condition; retentive flags stay until reset or control supply loss.
// - faults latch retentively by default after power-up.
// - undervoltage raised without mains recovers alone via mains wait.
// - undervoltage raised with mains present stays latched like others.
// - control supply loss enters power-down; on return goes to fault if lost while monitoring, else to mains wait.
// - in fault, keep monitoring; start lock timer once no fault is live.
// - each fault reports its numeric code; braking overvoltage has none.
// - lock times are 5 s, 10 s, 0.1 s, 100 s or none per fault.
// - only listed sources warn; braking overvoltage warns and never faults.
// - reset needs no live fault and the longest lock time elapsed.
// - auto restart enabled at 1 returns to mains wait when allowed.
// - a rising restore input edge returns to mains wait when allowed.
// - a serial reset command also clears faults when allowed.
// - control supply loss clears latched faults and the lock timer.
// - energy faults also need their accumulator discharged before reset.
// - braking and cable energy warn above 50 % (charge energy does not); all four fault at 100 %.
// - braking and charge accumulators drop 1 % per 0.5 s, retained.
// - cable accumulators drop 1 % per 24.8 s, retained.
`timescale 1ns/1ps
module supply_fault_supervisor
   import supply_fault_pkg::*;
#(
   parameter int TICK_CYCLES_P = supply_fault_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // monitors and supplies
   input wire logic [supply_fault_pkg::NUM_SRC-1:0] limit_violation,
   input wire logic [3:0] energy_charge,
   input wire logic mains_input,
   input wire logic control_supply,
   input wire logic dc_bus_output_ok,
   // restore sources
   input wire logic restore_input,
   input wire logic serial_reset_cmd,
   // parameter access
   input wire logic [11:0] param_addr,
   input wire logic param_wr,
   input wire logic [15:0] param_wdata,
   output logic [15:0] param_rdata,
   // status
   output logic trip_contact,
   output supply_fault_pkg::lamp_t status_lamp,
   output supply_fault_pkg::supply_state_t state,
   output logic [4:0] fault_code,
   output logic [supply_fault_pkg::NUM_SRC-1:0] dynamic_warning_class,
   output logic [supply_fault_pkg::NUM_SRC-1:0] dynamic_fault_class,
   output logic [supply_fault_pkg::NUM_SRC-1:0] latched_fault_class,
   output logic [supply_fault_pkg::NUM_SRC-1:0] latched_warning_class
);
   import supply_fault_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // tick and accumulators

   logic [31:0] tick_cnt;
   logic tick;
   logic [6:0] brake_level;
   logic [6:0] charge_level;
   logic [6:0] cable1_level;
   logic [6:0] cable2_level;
   logic [3:0] acc_full;
   logic [3:0] acc_half;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tick_cnt <= 32'h0;
         tick <= 1'b0;
      end else if (tick_cnt >= 32'(TICK_CYCLES_P - 1)) begin
         tick_cnt <= 32'h0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick <= 1'b0;
      end
   end

   energy_accumulator #(.STEP_TICKS(BRAKE_STEP_TICKS)) u_brake_acc (
      .clk_sys(clk_sys), .reset(reset), .tick(tick), .charge(energy_charge[0]),
      .level(brake_level), .full(acc_full[0]), .above_half(acc_half[0])
   );
   energy_accumulator #(.STEP_TICKS(BRAKE_STEP_TICKS)) u_charge_acc (
      .clk_sys(clk_sys), .reset(reset), .tick(tick), .charge(energy_charge[1]),
      .level(charge_level), .full(acc_full[1]), .above_half(acc_half[1])
   );
   energy_accumulator #(.STEP_TICKS(CABLE_STEP_TICKS)) u_cable1_acc (
      .clk_sys(clk_sys), .reset(reset), .tick(tick), .charge(energy_charge[2]),
      .level(cable1_level), .full(acc_full[2]), .above_half(acc_half[2])
   );
   energy_accumulator #(.STEP_TICKS(CABLE_STEP_TICKS)) u_cable2_acc (
      .clk_sys(clk_sys), .reset(reset), .tick(tick), .charge(energy_charge[3]),
      .level(cable2_level), .full(acc_full[3]), .above_half(acc_half[3])
   );

   ////////////////////////////////////////////////////////////////////////
   // live conditions and classes

   logic [NUM_SRC-1:0] acc_fault_vec;
   logic [NUM_SRC-1:0] acc_warn_vec;
   logic [NUM_SRC-1:0] live_fault;
   logic [NUM_SRC-1:0] live_warn;
   logic [NUM_SRC-1:0] new_fault;
   logic energy_clear;
   logic fault_active;
   logic monitoring;

   always_comb begin
      acc_fault_vec = '0;
      acc_warn_vec = '0;
      acc_fault_vec[F_BRAKE_ENERGY] = acc_full[0];
      acc_fault_vec[F_CHARGE_ENERGY] = acc_full[1];
      acc_fault_vec[F_CABLE_CH1] = acc_full[2];
      acc_fault_vec[F_CABLE_CH2] = acc_full[3];
      acc_warn_vec[F_BRAKE_ENERGY] = acc_half[0];
      acc_warn_vec[F_CHARGE_ENERGY] = acc_half[1];
      acc_warn_vec[F_CABLE_CH1] = acc_half[2];
      acc_warn_vec[F_CABLE_CH2] = acc_half[3];
   end

   assign live_fault = (limit_violation | acc_fault_vec) & FAULT_MASK;
   assign live_warn = (limit_violation | acc_warn_vec) & WARN_MASK;
   assign fault_active = |live_fault;
   assign monitoring = (state == ST_BUS_CHECK) || (state == ST_OPERATIONAL) ||
                       (state == ST_WARNING) || (state == ST_FAULT);
   assign new_fault = live_fault & ~latched_fault_class;

   // an energy fault may only be cleared once its accumulator is empty
   assign energy_clear = !(latched_fault_class[F_BRAKE_ENERGY] && brake_level != LEVEL_EMPTY) &&
                         !(latched_fault_class[F_CHARGE_ENERGY] && charge_level != LEVEL_EMPTY) &&
                         !(latched_fault_class[F_CABLE_CH1] && cable1_level != LEVEL_EMPTY) &&
                         !(latched_fault_class[F_CABLE_CH2] && cable2_level != LEVEL_EMPTY);

   ////////////////////////////////////////////////////////////////////////
   // parameter registers

   logic [15:0] fault_hold_time;
   logic [15:0] auto_restart_enable;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         fault_hold_time <= FAULT_HOLD_TIME_RESET;
         auto_restart_enable <= AUTO_RESTART_RESET;
      end else if (param_wr) begin
         if (param_addr == REG_FAULT_HOLD_TIME) begin
            fault_hold_time <= param_wdata;
         end
         if (param_addr == REG_AUTO_RESTART) begin
            auto_restart_enable <= param_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lock timer and reset acceptance

   logic [15:0] hold_need;
   logic [15:0] hold_cnt;
   logic restore_q;
   logic clear_ok;
   logic reset_req;
   logic uv_no_mains;
   logic pd_from_run;
   logic uv_auto;
   logic leave_fault;

   // fault_hold_time acts as a floor on the longest per-fault lock time
   assign hold_need = (max_lock(latched_fault_class) > fault_hold_time) ?
                      max_lock(latched_fault_class) : fault_hold_time;
   assign clear_ok = !fault_active && (hold_cnt >= hold_need) && energy_clear;
   assign reset_req = (auto_restart_enable == AUTO_RESTART_ON) ||
                      (restore_input && !restore_q) ||
                      serial_reset_cmd;
   assign uv_auto = uv_no_mains && (latched_fault_class == (NUM_SRC'(1) << F_UNDERVOLT)) && mains_input;
   assign leave_fault = (state == ST_FAULT) && ((clear_ok && reset_req) || uv_auto);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         restore_q <= 1'b0;
      end else begin
         restore_q <= restore_input;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset || !control_supply || state != ST_FAULT) begin
         hold_cnt <= 16'h0000;
      end else if (fault_active) begin
         hold_cnt <= 16'h0000;
      end else if (tick && hold_cnt != 16'hffff) begin
         hold_cnt <= hold_cnt + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault and warning flags

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dynamic_fault_class <= '0;
         dynamic_warning_class <= '0;
      end else begin
         dynamic_fault_class <= live_fault;
         dynamic_warning_class <= live_warn;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset || !control_supply) begin
         latched_fault_class <= '0;
         latched_warning_class <= '0;
         uv_no_mains <= 1'b0;
      end else if (state == ST_POWER_DOWN) begin
         if (pd_from_run) begin
            latched_fault_class[F_LOGIC_MISSING] <= 1'b1;
         end
      end else if (leave_fault) begin
         // a clearing event that coincides with a new live fault keeps it
         latched_fault_class <= live_fault;
         latched_warning_class <= live_warn;
         uv_no_mains <= 1'b0;
      end else if (monitoring) begin
         latched_fault_class <= latched_fault_class | live_fault;
         latched_warning_class <= latched_warning_class | live_warn;
         if (new_fault[F_UNDERVOLT]) begin
            uv_no_mains <= !mains_input;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state machine

   supply_state_t next_state;

   always_comb begin
      next_state = state;
      case (state)
         ST_MAINS_WAIT: begin
            if (mains_input) begin
               next_state = ST_STARTUP;
            end
         end
         ST_STARTUP: next_state = ST_BUS_CHECK;
         ST_BUS_CHECK: begin
            if (fault_active) begin
               next_state = ST_FAULT;
            end else if (dc_bus_output_ok) begin
               next_state = ST_OPERATIONAL;
            end
         end
         ST_OPERATIONAL, ST_WARNING: begin
            if (fault_active) begin
               next_state = ST_FAULT;
            end else if (|live_warn) begin
               next_state = ST_WARNING;
            end else begin
               next_state = ST_OPERATIONAL;
            end
         end
         ST_FAULT: begin
            if (leave_fault) begin
               next_state = ST_MAINS_WAIT;
            end
         end
         ST_POWER_DOWN: next_state = pd_from_run ? ST_FAULT : ST_MAINS_WAIT;
         default: next_state = ST_MAINS_WAIT;
      endcase
      if (!control_supply) begin
         next_state = ST_POWER_DOWN;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state <= ST_MAINS_WAIT;
         pd_from_run <= 1'b0;
      end else begin
         state <= next_state;
         if (!control_supply && state != ST_POWER_DOWN) begin
            pd_from_run <= monitoring;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         trip_contact <= 1'b0;
         status_lamp <= LAMP_OFF;
         fault_code <= 5'h00;
      end else begin
         // contact closed only outside fault and power-down
         trip_contact <= (next_state != ST_FAULT) && (next_state != ST_POWER_DOWN);
         case (next_state)
            ST_FAULT: status_lamp <= LAMP_RED;
            ST_WARNING: status_lamp <= LAMP_ORANGE;
            ST_OPERATIONAL: status_lamp <= LAMP_GREEN;
            default: status_lamp <= LAMP_OFF;
         endcase
         fault_code <= first_code(latched_fault_class);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         param_rdata <= 16'h0000;
      end else begin
         case (param_addr)
            REG_FAULT_HOLD_TIME: param_rdata <= fault_hold_time;
            REG_AUTO_RESTART: param_rdata <= auto_restart_enable;
            default: param_rdata <= 16'h0000;
         endcase
      end
   end

endmodule // supply_fault_supervisor

//--- bench/supply_fault_supervisor_monitor.sv
// assertion checker for the supply fault supervisor
// assumes it is bound to the supervisor top and sees only its ports
`timescale 1ns/1ps
module supply_fault_supervisor_monitor
   import supply_fault_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // watched inputs
   input wire logic [supply_fault_pkg::NUM_SRC-1:0] limit_violation,
   input wire logic control_supply,
   // watched outputs
   input wire logic trip_contact,
   input wire supply_fault_pkg::lamp_t status_lamp,
   input wire supply_fault_pkg::supply_state_t state,
   input wire logic [4:0] fault_code,
   input wire logic [supply_fault_pkg::NUM_SRC-1:0] dynamic_warning_class,
   input wire logic [supply_fault_pkg::NUM_SRC-1:0] dynamic_fault_class,
   input wire logic [supply_fault_pkg::NUM_SRC-1:0] latched_fault_class
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic watching;
   assign watching = state inside {ST_BUS_CHECK, ST_OPERATIONAL, ST_WARNING};
   ////////////////////////////////////////////////////////////////////////
   a_fault_entry: assert property (watching && control_supply && |(limit_violation & FAULT_MASK)
      |=> state == ST_FAULT) else $error("no fault entry on live fault");
   a_trip_open: assert property (state == ST_FAULT |-> !trip_contact)
      else $error("trip contact closed in fault");
   a_lamp_red: assert property (state == ST_FAULT |-> status_lamp == LAMP_RED)
      else $error("lamp not red in fault");
   a_flag_retained: assert property (state == ST_FAULT && $past(state) == ST_FAULT
      |-> ($past(latched_fault_class) & ~latched_fault_class) == '0) else $error("latched flag dropped");
   a_dynamic_follow: assert property (control_supply && $past(control_supply) && !$past(reset)
      |-> (dynamic_fault_class & ~ENERGY_MASK) == ($past(limit_violation) & FAULT_MASK & ~ENERGY_MASK))
      else $error("dynamic fault wrong");
   a_warn_class: assert property (control_supply && $past(control_supply) && !$past(reset)
      |-> (dynamic_warning_class & ~ENERGY_MASK) == ($past(limit_violation) & WARN_MASK & ~ENERGY_MASK))
      else $error("warning class wrong");
   a_brake_never_fault: assert property (!latched_fault_class[F_BRAKE_OVERVOLT]
      && !dynamic_fault_class[F_BRAKE_OVERVOLT]) else $error("braking overvoltage faulted");
   a_supply_loss: assert property (!control_supply
      |=> state == ST_POWER_DOWN && !trip_contact && latched_fault_class == '0) else $error("bad power down");
   a_hold_live: assert property (state == ST_FAULT && control_supply
      && |(limit_violation & FAULT_MASK & 21'h1ffffe) |=> state == ST_FAULT) else $error("fault left while live");
   a_code_single: assert property ($past(latched_fault_class) == 21'h000002
      && latched_fault_class == 21'h000002 |-> fault_code == 5'h02) else $error("fault code not 2");
   c_fault: cover property (watching ##1 state == ST_FAULT);
   c_power_down: cover property (state == ST_POWER_DOWN ##1 state == ST_FAULT);
   c_restore: cover property (state == ST_FAULT ##1 state == ST_MAINS_WAIT);
endmodule // supply_fault_supervisor_monitor

bind supply_fault_supervisor supply_fault_supervisor_monitor mon_i (.*);

//--- bench/supply_plant_model.sv
// plant model: mains source, trip contact and dc bus feedback
// assumes trip_contact high means the contact is closed
`timescale 1ns/1ps
module supply_plant_model (
   // clock
   input wire logic clk_sys,
   // grid and contact
   input wire logic grid_on,
   input wire logic trip_contact,
   // sensed feedback
   output logic mains_input,
   output logic dc_bus_output_ok
);
   logic [1:0] charge_dly;
   // sensed upstream of the contact
   assign mains_input = grid_on;
   // charges in two closed cycles, drops at once
   always_ff @(posedge clk_sys) begin
      charge_dly <= {charge_dly[0], trip_contact & grid_on};
   end
   assign dc_bus_output_ok = &charge_dly & trip_contact;
endmodule // supply_plant_model

//--- bench/test_supply_fault_supervisor.sv
// self-checking bench for the supply fault supervisor
// assumes the plant model supplies mains and bus feedback
`timescale 1ns/1ps
module test_supply_fault_supervisor;
   import supply_fault_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [NUM_SRC-1:0] limit_violation = '0;
   logic [3:0] energy_charge = 4'h0;
   logic grid_on = 1'b1;
   logic control_supply = 1'b1;
   logic restore_input = 1'b0;
   logic serial_reset_cmd = 1'b0;
   logic [11:0] param_addr = 12'h000;
   logic param_wr = 1'b0;
   logic [15:0] param_wdata = 16'h0000;
   logic [15:0] param_rdata;
   logic mains_input;
   logic dc_bus_output_ok;
   logic trip_contact;
   lamp_t status_lamp;
   supply_state_t state;
   logic [4:0] fault_code;
   logic [NUM_SRC-1:0] dyn_warn;
   logic [NUM_SRC-1:0] lat_fault;
   int n_errors = 0;
   int compares = 0;
   always #50 clk_sys = ~clk_sys;
   supply_fault_supervisor #(.TICK_CYCLES_P(4)) supply_fault_supervisor_i (.*, .dynamic_warning_class(dyn_warn),
      .dynamic_fault_class(), .latched_fault_class(lat_fault), .latched_warning_class());
   supply_plant_model supply_plant_model_i (.*);
   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      param_addr = a;
      param_wdata = d;
      param_wr = 1'b1;
      tick(1);
      param_wr = 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      param_addr = a;
      tick(1);
      chk("param_rdata", {16'h0000, exp}, {16'h0000, param_rdata});
   endtask
   task automatic chk_st(input supply_state_t s);
      chk("state", 32'(s), 32'(state));
   endtask
   // one request edge, then check state
   task automatic req(input logic use_restore, input supply_state_t exp);
      restore_input = use_restore;
      serial_reset_cmd = !use_restore;
      tick(1);
      restore_input = 1'b0;
      serial_reset_cmd = 1'b0;
      chk_st(exp);
   endtask
   task automatic wait_state(input supply_state_t s, input int lim);
      for (int i = 0; i < lim && state !== s; i++) begin
         tick(1);
      end
      chk_st(s);
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #2000000;
      n_errors++;
      close_out();
   end
   initial begin
      tick(4);
      reset = 1'b0;
      rd(REG_FAULT_HOLD_TIME, 16'h0000);
      rd(REG_AUTO_RESTART, 16'h0000);
      wr(REG_FAULT_HOLD_TIME, 16'h0003);
      wr(12'h123, 16'hbeef);
      rd(REG_FAULT_HOLD_TIME, 16'h0003);
      rd(12'h123, 16'h0000);
      $display("test registers done");
      wait_state(ST_OPERATIONAL, 100);
      limit_violation[F_OVERVOLT] = 1'b1;
      tick(1);
      chk_st(ST_FAULT);
      chk("trip_contact", 32'h0, 32'(trip_contact));
      chk("status_lamp", 32'(LAMP_RED), 32'(status_lamp));
      chk("latched_fault_class", 32'h000002, 32'(lat_fault));
      limit_violation = '0;
      tick(1);
      chk("fault_code", 32'h02, 32'(fault_code));
      tick(170);
      req(1'b0, ST_FAULT);
      chk("latched_fault_class", 32'h000002, 32'(lat_fault));
      tick(40);
      req(1'b1, ST_MAINS_WAIT);
      $display("test overvoltage done");
      wait_state(ST_OPERATIONAL, 100);
      wr(REG_AUTO_RESTART, AUTO_RESTART_ON);
      limit_violation = 21'h000028;
      tick(1);
      chk("latched_fault_class", 32'h000028, 32'(lat_fault));
      limit_violation = '0;
      tick(1);
      chk("fault_code", 32'h04, 32'(fault_code));
      tick(350);
      chk_st(ST_FAULT);
      wait_state(ST_MAINS_WAIT, 100);
      wr(REG_AUTO_RESTART, 16'h0000);
      $display("test auto restart done");
      wait_state(ST_OPERATIONAL, 100);
      limit_violation[F_BRAKE_OVERVOLT] = 1'b1;
      tick(2);
      chk("dynamic_warning_class", 32'h000100, 32'(dyn_warn));
      chk("trip_contact", 32'h1, 32'(trip_contact));
      limit_violation = '0;
      $display("test braking overvoltage done");
      wait_state(ST_OPERATIONAL, 100);
      limit_violation[F_UNDERVOLT] = 1'b1;
      tick(1);
      limit_violation = '0;
      grid_on = 1'b0;
      tick(3);
      grid_on = 1'b1;
      tick(3);
      chk_st(ST_FAULT);
      control_supply = 1'b0;
      tick(2);
      chk_st(ST_POWER_DOWN);
      chk("latched_fault_class", 32'h0, 32'(lat_fault));
      control_supply = 1'b1;
      wait_state(ST_FAULT, 5);
      tick(2);
      chk("fault_code", 32'h0b, 32'(fault_code));
      tick(20);
      req(1'b0, ST_MAINS_WAIT);
      $display("test supply loss done");
      wait_state(ST_OPERATIONAL, 100);
      grid_on = 1'b0;
      limit_violation[F_UNDERVOLT] = 1'b1;
      tick(1);
      limit_violation = '0;
      tick(5);
      chk_st(ST_FAULT);
      grid_on = 1'b1;
      wait_state(ST_MAINS_WAIT, 10);
      $display("test undervoltage without mains done");
      wait_state(ST_OPERATIONAL, 100);
      repeat (115) begin
         energy_charge = 4'h1;
         tick(1);
         energy_charge = 4'h0;
         tick(1);
      end
      chk_st(ST_FAULT);
      tick(1000);
      req(1'b0, ST_FAULT);
      tick(1500);
      req(1'b0, ST_MAINS_WAIT);
      $display("test energy discharge done");
      close_out();
   end
endmodule // test_supply_fault_supervisor
